// file: hw/asl_cfg.svh
/*
 * Constants of the AUX snoop lane manager: clock rate, timing figures,
 * AUX command and DPCD addresses, field widths and reset values.
 * Assumes it is included by bare name from the package file and from asl_top.
 */
`ifndef ASL_CFG_SVH
`define ASL_CFG_SVH

`define ASL_CLK_HZ          40000000
`define ASL_LANES           4
`define ASL_EQ_W            4
`define ASL_DEBOUNCE_MS     2
`define ASL_CFG_HOLD_US     10
`define ASL_SENSE_W         3
`define ASL_FILL_CYC        4
`define ASL_AUX_NATIVE_WR   4'h8
`define ASL_DPCD_LANE_COUNT 20'h00101
`define ASL_DPCD_POWER      20'h00600
`define ASL_LANE_COUNT_W    5
`define ASL_POWER_W         3
`define ASL_PWR_D0          3'h1
`define ASL_PWR_D3          3'h2
`define ASL_PWR_D3_AUX      3'h5
`define ASL_LANE_COUNT_RST  5'h04

`endif

// file: hw/asl_debounce.sv
/*
 * Synchroniser and debouncer for one slow pin.
 * Assumes the pin is asynchronous to clk; the output level changes only
 * after the synchronised input has held a new value for STABLE_CYC cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module asl_debounce
	import asl_pkg::*;
#(
	parameter int STABLE_CYC = 80000,
	parameter int CNT_W      = 17
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin,
	output logic      level
);

	logic             s1_q;
	logic             s2_q;
	logic             s3_q;
	logic             level_q;
	logic [CNT_W-1:0] cnt_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A new level is counted only while the last two stages agree.
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q   <= '0;
			level_q <= 1'b0;
		end else if (s2_q == s3_q && s3_q != level_q) begin
			if (cnt_q == CNT_W'(STABLE_CYC - 1)) begin
				level_q <= s3_q;
				cnt_q   <= '0;
			end else begin
				cnt_q <= cnt_q + CNT_W'(1);
			end
		end else begin
			cnt_q <= '0;
		end
	end

	assign level = level_q;

endmodule

`default_nettype wire

// file: hw/asl_pkg.sv
/*
 * Types of the AUX snoop lane manager.
 * Assumes asl_cfg.svh is on the include path.
 */
`include "asl_cfg.svh"

package asl_pkg;

	// Resolved level of a four-level pin; the order gives codes 00, 01, 10, 11.
	typedef enum logic [1:0] {
		LVL_0,
		LVL_R,
		LVL_F,
		LVL_1
	} asl_level_t;

	// Position inside a source-to-sink AUX request.
	typedef enum logic [2:0] {
		ST_CMD,
		ST_ADDR_MID,
		ST_ADDR_LO,
		ST_LEN,
		ST_DATA,
		ST_SKIP
	} asl_parse_t;

endpackage

// file: hw/asl_top.sv
/*
 * Lane and configuration manager of a four-lane linear re-driver.
 * Watches decoded AUX request bytes, latches the four-level strap pins,
 * debounces the path-enable and hot-plug pins and drives lane enables
 * and equalizer settings. Assumes an AUX front end that delivers request
 * bytes on REF_CLK and comparator outputs for each four-level pin.
 */
`timescale 1ns/1ps
`default_nettype none

`include "asl_cfg.svh"

module asl_top
	import asl_pkg::*;
#(
	parameter int DEBOUNCE_CYC = `ASL_DEBOUNCE_MS * (`ASL_CLK_HZ / 1000),
	parameter int DEB_CNT_W    = 17,
	parameter int LANES        = `ASL_LANES
) (
	input  wire logic                                 REF_CLK,
	input  wire logic                                 RST,
	input  wire logic [7:0]                           AUX_BYTE,
	input  wire logic                                 AUX_BYTE_VALID,
	input  wire logic                                 AUX_FRAME,
	input  wire logic                                 AUX_FROM_SOURCE,
	input  wire logic                                 DP_PATH_ENABLE_PIN,
	input  wire logic                                 HOT_PLUG_DETECT_INPUT,
	input  wire logic                                 SNOOP_DISABLE_PIN,
	input  wire logic [`ASL_SENSE_W-1:0]              HOST_SELECT_SENSE,
	input  wire logic [`ASL_SENSE_W-1:0]              TARGET_ADDRESS_PIN_LOW_SENSE,
	input  wire logic [2*`ASL_SENSE_W-1:0]            EQ_GAIN_SELECT_PINS_SENSE,
	input  wire logic                                 REG_SNOOP_DISABLE,
	input  wire logic [LANES-1:0]                     REG_LANE_ENABLE,
	input  wire logic                                 REG_DP_PATH_ENABLE,
	input  wire logic [LANES*`ASL_EQ_W-1:0]           REG_EQ_SEL,
	output logic      [LANES-1:0]                     LANE_ENABLE,
	output logic                                      DP_PATH_ACTIVE,
	output logic                                      HPD_LEVEL,
	output logic                                      I2C_MODE,
	output logic                                      CFG_LATCHED,
	output logic                                      CFG_PULL_ENABLE,
	output logic      [1:0]                           TARGET_ADDR_LEVEL,
	output logic      [LANES*`ASL_EQ_W-1:0]           EQ_SETTING,
	output logic                                      SNOOP_ACTIVE,
	output logic      [`ASL_LANE_COUNT_W-1:0]         LANE_COUNT_CAPTURED,
	output logic      [`ASL_POWER_W-1:0]              POWER_STATE_CAPTURED
);

	// ****************************************************************
	// Constants and helper functions
	// ****************************************************************

	localparam int CFG_HOLD_CYC = `ASL_CFG_HOLD_US * (`ASL_CLK_HZ / 1000000);
	localparam int HOLD_W       = 10;
	localparam int FILL_W       = 2;
	localparam int SENSE_ALL    = 4 * `ASL_SENSE_W;

	// Comparator outputs form a thermometer code; the number of set bits
	// gives the level, so a single flipped comparator picks a neighbour.
	function automatic asl_level_t resolve_level(input logic [`ASL_SENSE_W-1:0] t);
		logic [1:0] ones;
		ones = 2'h0;
		for (int i = 0; i < `ASL_SENSE_W; i++) begin
			ones = ones + {1'b0, t[i]};
		end
		return asl_level_t'(ones);
	endfunction

	// Lanes below the captured count are on; counts above four clamp.
	function automatic logic [LANES-1:0] count_mask(input logic [`ASL_LANE_COUNT_W-1:0] n);
		logic [LANES-1:0] m;
		m = '0;
		for (int i = 0; i < LANES; i++) begin
			m[i] = (`ASL_LANE_COUNT_W'(i) < n);
		end
		return m;
	endfunction

	function automatic logic is_d3(input logic [`ASL_POWER_W-1:0] p);
		return (p == `ASL_PWR_D3) || (p == `ASL_PWR_D3_AUX);
	endfunction

	// ****************************************************************
	// Debounced and synchronised slow pins
	// ****************************************************************

	logic path_pin_lvl;
	logic hpd_lvl;
	logic snoop_pin_lvl;

	asl_debounce #(.STABLE_CYC(DEBOUNCE_CYC), .CNT_W(DEB_CNT_W)) u_deb_path (
		.clk   (REF_CLK),
		.rst   (RST),
		.pin   (DP_PATH_ENABLE_PIN),
		.level (path_pin_lvl)
	);

	asl_debounce #(.STABLE_CYC(DEBOUNCE_CYC), .CNT_W(DEB_CNT_W)) u_deb_hpd (
		.clk   (REF_CLK),
		.rst   (RST),
		.pin   (HOT_PLUG_DETECT_INPUT),
		.level (hpd_lvl)
	);

	// The snoop-disable pin is a strap-like level; it passes the same block
	// with STABLE_CYC of 1, so it is only synchronised, not debounced.
	asl_debounce #(.STABLE_CYC(1), .CNT_W(DEB_CNT_W)) u_sync_snoop (
		.clk   (REF_CLK),
		.rst   (RST),
		.pin   (SNOOP_DISABLE_PIN),
		.level (snoop_pin_lvl)
	);

	// ****************************************************************
	// Four-level pin latch
	// ****************************************************************

	logic [SENSE_ALL-1:0] sense_s1_q;
	logic [SENSE_ALL-1:0] sense_s2_q;
	logic [SENSE_ALL-1:0] sense_s3_q;
	logic [FILL_W-1:0]    fill_q;
	logic                 latched_q;
	logic [HOLD_W-1:0]    hold_q;
	logic                 pull_q;
	asl_level_t           host_sel_q;
	asl_level_t           addr_lvl_q;
	asl_level_t           eq_hi_q;
	asl_level_t           eq_lo_q;
	logic                 gpio_mode;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			sense_s1_q <= '0;
			sense_s2_q <= '0;
			sense_s3_q <= '0;
		end else begin
			sense_s1_q <= {HOST_SELECT_SENSE, TARGET_ADDRESS_PIN_LOW_SENSE,
				EQ_GAIN_SELECT_PINS_SENSE};
			sense_s2_q <= sense_s1_q;
			sense_s3_q <= sense_s2_q;
		end
	end

	// The pins are caught once the synchroniser has filled and its last two
	// stages agree, which stands for the rising edge of the internal reset.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			fill_q     <= '0;
			latched_q  <= 1'b0;
			host_sel_q <= LVL_0;
			addr_lvl_q <= LVL_0;
			eq_hi_q    <= LVL_0;
			eq_lo_q    <= LVL_0;
		end else if (!latched_q) begin
			if (fill_q == FILL_W'(`ASL_FILL_CYC - 1) && sense_s2_q == sense_s3_q) begin
				latched_q  <= 1'b1;
				host_sel_q <= resolve_level(sense_s3_q[4*`ASL_SENSE_W-1:3*`ASL_SENSE_W]);
				addr_lvl_q <= resolve_level(sense_s3_q[3*`ASL_SENSE_W-1:2*`ASL_SENSE_W]);
				eq_hi_q    <= resolve_level(sense_s3_q[2*`ASL_SENSE_W-1:`ASL_SENSE_W]);
				eq_lo_q    <= resolve_level(sense_s3_q[`ASL_SENSE_W-1:0]);
			end else begin
				fill_q <= fill_q + FILL_W'(1);
			end
		end
	end

	// Pulls stay on until the hold time after the latch has run out.
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			hold_q <= '0;
			pull_q <= 1'b1;
		end else if (latched_q && pull_q) begin
			if (hold_q == HOLD_W'(CFG_HOLD_CYC - 1)) begin
				pull_q <= 1'b0;
			end else begin
				hold_q <= hold_q + HOLD_W'(1);
			end
		end
	end

	assign gpio_mode = (host_sel_q == LVL_0);

	// ****************************************************************
	// AUX request parser
	// ****************************************************************

	asl_parse_t             st_q;
	logic [19:0]            addr_q;
	logic                   is_wr_q;
	logic                   frame_q;
	logic                   pend_cnt_v_q;
	logic                   pend_pwr_v_q;
	logic [7:0]             pend_cnt_q;
	logic [7:0]             pend_pwr_q;
	logic                   take;
	logic                   frame_end;

	// Only source-to-sink request bytes are looked at; nothing is driven
	// back onto the channel.
	assign take      = AUX_BYTE_VALID && AUX_FRAME && AUX_FROM_SOURCE;
	assign frame_end = frame_q && !AUX_FRAME;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			frame_q <= 1'b0;
		end else begin
			frame_q <= AUX_FRAME && AUX_FROM_SOURCE;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST || !AUX_FRAME) begin
			st_q    <= ST_CMD;
			addr_q  <= '0;
			is_wr_q <= 1'b0;
		end else if (take) begin
			unique case (st_q)
				ST_CMD: begin
					is_wr_q     <= (AUX_BYTE[7:4] == `ASL_AUX_NATIVE_WR);
					addr_q[19:16] <= AUX_BYTE[3:0];
					st_q        <= ST_ADDR_MID;
				end
				ST_ADDR_MID: begin
					addr_q[15:8] <= AUX_BYTE;
					st_q         <= ST_ADDR_LO;
				end
				ST_ADDR_LO: begin
					addr_q[7:0] <= AUX_BYTE;
					st_q        <= ST_LEN;
				end
				ST_LEN:  st_q <= is_wr_q ? ST_DATA : ST_SKIP;
				ST_DATA: addr_q <= addr_q + 20'h00001;
				ST_SKIP: st_q <= ST_SKIP;
			endcase
		end
	end

	// Data bytes of a burst are matched against each address in turn and
	// held as pending until the request frame ends.
	always_ff @(posedge REF_CLK) begin
		if (RST || frame_end) begin
			pend_cnt_v_q <= 1'b0;
			pend_pwr_v_q <= 1'b0;
			pend_cnt_q   <= '0;
			pend_pwr_q   <= '0;
		end else if (take && st_q == ST_DATA) begin
			if (addr_q == `ASL_DPCD_LANE_COUNT) begin
				pend_cnt_v_q <= 1'b1;
				pend_cnt_q   <= AUX_BYTE;
			end
			if (addr_q == `ASL_DPCD_POWER) begin
				pend_pwr_v_q <= 1'b1;
				pend_pwr_q   <= AUX_BYTE;
			end
		end
	end

	logic [`ASL_LANE_COUNT_W-1:0] lane_cnt_q;
	logic [`ASL_POWER_W-1:0]      pwr_q;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			lane_cnt_q <= `ASL_LANE_COUNT_RST;
			pwr_q      <= `ASL_PWR_D0;
		end else if (frame_end) begin
			if (pend_cnt_v_q) begin
				lane_cnt_q <= pend_cnt_q[`ASL_LANE_COUNT_W-1:0];
			end
			if (pend_pwr_v_q) begin
				pwr_q <= pend_pwr_q[`ASL_POWER_W-1:0];
			end
		end
	end

	// ****************************************************************
	// Lane and equalizer control
	// ****************************************************************

	logic                          snoop_off;
	logic                          path_en;
	logic [LANES-1:0]              lane_d;
	logic [LANES-1:0]              lane_q;
	logic                          path_q;
	logic [LANES*`ASL_EQ_W-1:0]    eq_d;
	logic [LANES*`ASL_EQ_W-1:0]    eq_q;

	// In register mode the snoop bit resets to enabled in the register
	// block, so snooping runs from reset unless software clears it.
	assign snoop_off = gpio_mode ? snoop_pin_lvl : REG_SNOOP_DISABLE;
	assign path_en   = gpio_mode ? path_pin_lvl : REG_DP_PATH_ENABLE;

	always_comb begin
		if (!latched_q || !path_en) begin
			lane_d = '0;
		end else if (snoop_off) begin
			lane_d = gpio_mode ? {LANES{1'b1}} : REG_LANE_ENABLE;
		end else if (is_d3(pwr_q)) begin
			lane_d = '0;
		end else begin
			lane_d = count_mask(lane_cnt_q);
		end
	end

	always_comb begin
		if (gpio_mode) begin
			eq_d = {LANES{eq_hi_q, eq_lo_q}};
		end else begin
			eq_d = REG_EQ_SEL;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			lane_q <= '0;
			path_q <= 1'b0;
		end else begin
			lane_q <= lane_d;
			path_q <= latched_q && path_en;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			eq_q <= '0;
		end else if (latched_q) begin
			eq_q <= eq_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************

	assign LANE_ENABLE          = lane_q;
	assign DP_PATH_ACTIVE       = path_q;
	assign HPD_LEVEL            = hpd_lvl;
	assign I2C_MODE             = latched_q && !gpio_mode;
	assign CFG_LATCHED          = latched_q;
	assign CFG_PULL_ENABLE      = pull_q;
	assign TARGET_ADDR_LEVEL    = addr_lvl_q;
	assign EQ_SETTING           = eq_q;
	assign SNOOP_ACTIVE         = latched_q && !snoop_off;
	assign LANE_COUNT_CAPTURED  = lane_cnt_q;
	assign POWER_STATE_CAPTURED = pwr_q;

endmodule

`default_nettype wire

// file: tb/asl_aux_model.sv
/* Source and sink on the AUX channel, as decoded request bytes.
   Assumes req is called just after a rising edge of clk. */
`timescale 1ns/1ps
`default_nettype none
module asl_aux_model (
	input  wire logic clk,
	output logic [7:0] aux_byte,
	output logic       aux_valid,
	output logic       aux_frame,
	output logic       aux_src
);
	// ****************
	// Frame driver
	// ****************
	initial begin
		aux_byte = 8'h5a;
		aux_valid = 1'b0;
		aux_frame = 1'b0;
		aux_src = 1'b0;
	end
	// Idle byte lines carry the inverse of the last byte, never a stale copy.
	task automatic req(input logic src, input logic [3:0] cmd, input logic [19:0] a,
		input logic [15:0] d, input int n, input int gap);
		logic [7:0] b [6];
		b = '{{cmd, a[19:16]}, a[15:8], a[7:0], 8'(n - 1), d[7:0], d[15:8]};
		aux_frame = 1'b1;
		aux_src = src;
		for (int i = 0; i < 4 + n; i++) begin
			aux_byte = b[i];
			aux_valid = 1'b1;
			@(posedge clk);
			#1;
			if (gap > 0) begin
				aux_valid = 1'b0;
				aux_byte = ~b[i];
				repeat (gap) @(posedge clk);
				#1;
			end
		end
		aux_valid = 1'b0;
		aux_frame = 1'b0;
		aux_src = 1'b0;
		aux_byte = ~b[3 + n];
		repeat (2) @(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire

// file: tb/asl_top_checker.sv
/* Port assertions of the lane manager.
   Assumes a bind onto asl_top with the same DEBOUNCE_CYC. */
`timescale 1ns/1ps
`default_nettype none
module asl_top_checker
	import asl_pkg::*;
#(
	parameter int DEBOUNCE_CYC = 80000
) (
	input wire logic        REF_CLK,
	input wire logic        RST,
	input wire logic        HOT_PLUG_DETECT_INPUT,
	input wire logic [3:0]  REG_LANE_ENABLE,
	input wire logic [15:0] REG_EQ_SEL,
	input wire logic [3:0]  LANE_ENABLE,
	input wire logic        DP_PATH_ACTIVE,
	input wire logic        HPD_LEVEL,
	input wire logic        I2C_MODE,
	input wire logic        CFG_LATCHED,
	input wire logic        CFG_PULL_ENABLE,
	input wire logic [1:0]  TARGET_ADDR_LEVEL,
	input wire logic [15:0] EQ_SETTING,
	input wire logic        SNOOP_ACTIVE,
	input wire logic [4:0]  LANE_COUNT_CAPTURED,
	input wire logic [2:0]  POWER_STATE_CAPTURED
);
	// ****************
	// Helper logic
	// ****************
	logic [3:0] exp_l;
	logic       d3;
	int         hi_q;
	int         lat_q;
	assign d3 = POWER_STATE_CAPTURED == 3'h2 || POWER_STATE_CAPTURED == 3'h5;
	assign exp_l = LANE_COUNT_CAPTURED > 5'h3 ? 4'hf :
		4'((5'h1 << LANE_COUNT_CAPTURED) - 5'h1);
	always_ff @(posedge REF_CLK) begin
		if (RST || !HOT_PLUG_DETECT_INPUT)
			hi_q <= 0;
		else if (hi_q < 1000000)
			hi_q <= hi_q + 1;
	end
	always_ff @(posedge REF_CLK) begin
		if (RST || !CFG_LATCHED)
			lat_q <= 0;
		else if (lat_q < 1000)
			lat_q <= lat_q + 1;
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	chk_d3_lanes_off: assert property (SNOOP_ACTIVE && d3 |=> LANE_ENABLE == 4'h0)
		else $error("lanes on in D3");
	chk_count_lanes: assert property (SNOOP_ACTIVE && DP_PATH_ACTIVE && !d3
		##1 DP_PATH_ACTIVE |-> LANE_ENABLE == $past(exp_l)) else $error("lanes off count");
	chk_pin_all_lanes: assert property (!I2C_MODE && CFG_LATCHED && !SNOOP_ACTIVE
		&& DP_PATH_ACTIVE ##1 DP_PATH_ACTIVE |-> LANE_ENABLE == 4'hf) else $error("pin force");
	chk_reg_lanes: assert property (I2C_MODE && !SNOOP_ACTIVE && DP_PATH_ACTIVE
		##1 DP_PATH_ACTIVE |-> LANE_ENABLE == $past(REG_LANE_ENABLE)) else $error("reg lanes");
	chk_path_off: assert property (!DP_PATH_ACTIVE ##1 !DP_PATH_ACTIVE |-> LANE_ENABLE == 4'h0)
		else $error("lanes with path off");
	chk_pull_hold: assert property (CFG_LATCHED && lat_q < 390 |-> CFG_PULL_ENABLE)
		else $error("pulls released early");
	chk_pull_free: assert property ($rose(CFG_LATCHED) |-> ##[390:410] !CFG_PULL_ENABLE)
		else $error("pulls kept");
	chk_cfg_frozen: assert property (CFG_LATCHED && $past(CFG_LATCHED, 2)
		|-> $stable(I2C_MODE) && $stable(TARGET_ADDR_LEVEL)) else $error("straps moved");
	chk_latch_time: assert property ($fell(RST) |-> ##[1:5] CFG_LATCHED)
		else $error("straps not latched");
	chk_eq_regs: assert property (I2C_MODE && $past(I2C_MODE)
		|-> EQ_SETTING == $past(REG_EQ_SEL)) else $error("eq not from regs");
	chk_hpd_debounce: assert property ($rose(HPD_LEVEL) |-> hi_q >= DEBOUNCE_CYC)
		else $error("hpd rose early");
endmodule
bind asl_top asl_top_checker #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) chk (.REF_CLK, .RST,
	.HOT_PLUG_DETECT_INPUT, .REG_LANE_ENABLE, .REG_EQ_SEL, .LANE_ENABLE, .DP_PATH_ACTIVE,
	.HPD_LEVEL, .I2C_MODE, .CFG_LATCHED, .CFG_PULL_ENABLE, .TARGET_ADDR_LEVEL, .EQ_SETTING,
	.SNOOP_ACTIVE, .LANE_COUNT_CAPTURED, .POWER_STATE_CAPTURED);
`default_nettype wire

// file: tb/testbench.sv
/* Self-checking bench of the lane manager: straps, debounce, snoop, register mode.
   Assumes asl_top, asl_aux_model and the bound checker are compiled. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int DEB = 8;
	logic        REF_CLK, RST, AUX_BYTE_VALID, AUX_FRAME, AUX_FROM_SOURCE;
	logic        DP_PATH_ENABLE_PIN, HOT_PLUG_DETECT_INPUT, SNOOP_DISABLE_PIN;
	logic        REG_SNOOP_DISABLE, REG_DP_PATH_ENABLE, DP_PATH_ACTIVE, HPD_LEVEL;
	logic        I2C_MODE, CFG_LATCHED, CFG_PULL_ENABLE, SNOOP_ACTIVE;
	logic [7:0]  AUX_BYTE;
	logic [2:0]  HOST_SELECT_SENSE, TARGET_ADDRESS_PIN_LOW_SENSE, POWER_STATE_CAPTURED;
	logic [5:0]  EQ_GAIN_SELECT_PINS_SENSE;
	logic [3:0]  REG_LANE_ENABLE, LANE_ENABLE;
	logic [15:0] REG_EQ_SEL, EQ_SETTING;
	logic [1:0]  TARGET_ADDR_LEVEL;
	logic [4:0]  LANE_COUNT_CAPTURED;
	logic [4:0]  cnt_tab [3] = '{5'h1, 5'h2, 5'h4};
	logic [3:0]  cnt_exp [3] = '{4'h1, 4'h3, 4'hf};
	logic [2:0]  pwr_tab [3] = '{3'h2, 3'h5, 3'h1};
	logic [3:0]  pwr_exp [3] = '{4'h0, 4'h0, 4'h3};
	int          bad_count = 0;
	int          checks = 0;
	int          cyc = 0;
	asl_aux_model aux (.clk(REF_CLK), .aux_byte(AUX_BYTE), .aux_valid(AUX_BYTE_VALID),
		.aux_frame(AUX_FRAME), .aux_src(AUX_FROM_SOURCE));
	asl_top #(.DEBOUNCE_CYC(DEB)) uut (.REF_CLK, .RST, .AUX_BYTE, .AUX_BYTE_VALID,
		.AUX_FRAME, .AUX_FROM_SOURCE, .DP_PATH_ENABLE_PIN, .HOT_PLUG_DETECT_INPUT,
		.SNOOP_DISABLE_PIN, .HOST_SELECT_SENSE, .TARGET_ADDRESS_PIN_LOW_SENSE,
		.EQ_GAIN_SELECT_PINS_SENSE, .REG_SNOOP_DISABLE, .REG_LANE_ENABLE,
		.REG_DP_PATH_ENABLE, .REG_EQ_SEL, .LANE_ENABLE, .DP_PATH_ACTIVE, .HPD_LEVEL,
		.I2C_MODE, .CFG_LATCHED, .CFG_PULL_ENABLE, .TARGET_ADDR_LEVEL, .EQ_SETTING,
		.SNOOP_ACTIVE, .LANE_COUNT_CAPTURED, .POWER_STATE_CAPTURED);
	// ****************
	// Tasks
	// ****************
	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge REF_CLK);
		#1;
	endtask
	task automatic final_report;
		if (bad_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		REF_CLK = 1'b0;
		forever #12.5 REF_CLK = ~REF_CLK;
	end
	always @(posedge REF_CLK) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			final_report();
		end
	end
	// ****************
	// Sequence
	// ****************
	initial begin
		RST = 1'b1;
		DP_PATH_ENABLE_PIN = 1'b0;
		HOT_PLUG_DETECT_INPUT = 1'b0;
		SNOOP_DISABLE_PIN = 1'b0;
		HOST_SELECT_SENSE = 3'h0;
		TARGET_ADDRESS_PIN_LOW_SENSE = 3'h7;
		EQ_GAIN_SELECT_PINS_SENSE = 6'h19;
		REG_SNOOP_DISABLE = 1'b0;
		REG_LANE_ENABLE = 4'ha;
		REG_DP_PATH_ENABLE = 1'b1;
		REG_EQ_SEL = 16'h1234;
		tick(8);
		cmp("lane_count", 16'h4, LANE_COUNT_CAPTURED);
		cmp("power", 16'h1, POWER_STATE_CAPTURED);
		cmp("pull", 16'h1, CFG_PULL_ENABLE);
		RST = 1'b0;
		tick(6);
		cmp("latched", 16'h1, CFG_LATCHED);
		cmp("i2c", 16'h0, I2C_MODE);
		cmp("snoop", 16'h1, SNOOP_ACTIVE);
		cmp("addr", 16'h3, TARGET_ADDR_LEVEL);
		cmp("eq", 16'h9999, EQ_SETTING);
		cmp("lanes", 16'h0, LANE_ENABLE);
		HOST_SELECT_SENSE = 3'h7;
		EQ_GAIN_SELECT_PINS_SENSE = 6'h00;
		DP_PATH_ENABLE_PIN = 1'b1;
		HOT_PLUG_DETECT_INPUT = 1'b1;
		tick(DEB);
		cmp("i2c", 16'h0, I2C_MODE);
		cmp("eq", 16'h9999, EQ_SETTING);
		cmp("hpd", 16'h0, HPD_LEVEL);
		HOT_PLUG_DETECT_INPUT = 1'b0;
		tick(1);
		HOT_PLUG_DETECT_INPUT = 1'b1;
		tick(DEB);
		cmp("hpd", 16'h0, HPD_LEVEL);
		cmp("path", 16'h1, DP_PATH_ACTIVE);
		tick(8);
		cmp("hpd", 16'h1, HPD_LEVEL);
		cmp("lanes", 16'hf, LANE_ENABLE);
		for (int i = 0; i < 3; i++) begin
			aux.req(1'b1, 4'h8, 20'h00101, 16'(cnt_tab[i]), 1, i);
			tick(3);
			cmp("lane_count", 16'(cnt_tab[i]), LANE_COUNT_CAPTURED);
			cmp("lanes", 16'(cnt_exp[i]), LANE_ENABLE);
		end
		aux.req(1'b0, 4'h8, 20'h00101, 16'h1, 1, 0);
		aux.req(1'b1, 4'h9, 20'h00101, 16'h1, 1, 0);
		tick(3);
		cmp("lanes", 16'hf, LANE_ENABLE);
		aux.req(1'b1, 4'h8, 20'h00100, 16'h0200, 2, 0);
		tick(3);
		cmp("lanes", 16'h3, LANE_ENABLE);
		for (int i = 0; i < 3; i++) begin
			aux.req(1'b1, 4'h8, 20'h00600, 16'(pwr_tab[i]), 1, 0);
			tick(3);
			cmp("power", 16'(pwr_tab[i]), POWER_STATE_CAPTURED);
			cmp("lanes", 16'(pwr_exp[i]), LANE_ENABLE);
		end
		SNOOP_DISABLE_PIN = 1'b1;
		tick(6);
		cmp("snoop", 16'h0, SNOOP_ACTIVE);
		cmp("lanes", 16'hf, LANE_ENABLE);
		SNOOP_DISABLE_PIN = 1'b0;
		tick(6);
		cmp("lanes", 16'h3, LANE_ENABLE);
		DP_PATH_ENABLE_PIN = 1'b0;
		tick(DEB + 6);
		cmp("lanes", 16'h0, LANE_ENABLE);
		tick(300);
		cmp("pull", 16'h0, CFG_PULL_ENABLE);
		HOST_SELECT_SENSE = 3'h1;
		RST = 1'b1;
		tick(3);
		RST = 1'b0;
		tick(6);
		cmp("i2c", 16'h1, I2C_MODE);
		cmp("eq", 16'h1234, EQ_SETTING);
		REG_SNOOP_DISABLE = 1'b1;
		tick(3);
		cmp("snoop", 16'h0, SNOOP_ACTIVE);
		cmp("lanes", 16'ha, LANE_ENABLE);
		REG_SNOOP_DISABLE = 1'b0;
		tick(3);
		cmp("lanes", 16'hf, LANE_ENABLE);
		final_report();
	end
endmodule
`default_nettype wire
